// *** sdram_cfg_pkg.sv ***
// constants, field layout and command types for the configuration and burst block
// assumes a single core clock; command pins are sampled on its rising edge
package sdram_cfg_pkg;

	// ==========================================================
	// configuration register layout
	localparam int CFG_W = 14;
	localparam int COL_W = 10;
	localparam int CNT_W = 11;

	typedef struct packed {
		logic [6:0] option_bits;
		logic [2:0] latency_field;
		logic wrap_select;
		logic [2:0] burst_len_field;
	} cfg_s;

	localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;

	// ==========================================================
	// field codes
	localparam logic [2:0] LAT_TWO = 3'h2;
	localparam logic [2:0] LAT_THREE = 3'h3;
	localparam logic [2:0] BL_ONE = 3'h0;
	localparam logic [2:0] BL_TWO = 3'h1;
	localparam logic [2:0] BL_FOUR = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic WRAP_SEQ = 1'b0;
	localparam logic WRAP_ILV = 1'b1;

	// burst word counts; full page is fixed for the four-bit organization
	localparam logic [CNT_W-1:0] WORDS_NONE = 11'h000;
	localparam logic [CNT_W-1:0] WORDS_ONE = 11'h001;
	localparam logic [CNT_W-1:0] WORDS_TWO = 11'h002;
	localparam logic [CNT_W-1:0] WORDS_FOUR = 11'h004;
	localparam logic [CNT_W-1:0] WORDS_EIGHT = 11'h008;
	localparam logic [CNT_W-1:0] PAGE_WORDS_X4 = 11'h400;
	localparam logic [CNT_W-1:0] PAGE_WORDS_X8 = 11'h200;
	localparam logic [CNT_W-1:0] PAGE_WORDS_X16 = 11'h100;
	localparam logic [CNT_W-1:0] PAGE_WORDS = PAGE_WORDS_X4;

	// ==========================================================
	// command pins
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} cmd_s;

	localparam logic [3:0] CMD_CONFIG_WRITE = 4'h0;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_BURST = 1'b1
	} burst_st_e;

endpackage : sdram_cfg_pkg

// *** burst_col_gen.sv ***
// burst column generator: column of the n-th word of a burst
// assumes mask has ones over the low bits that wrap inside the aligned block
`timescale 1ns/1ps
module burst_col_gen
	import sdram_cfg_pkg::*;
(
	input wire logic [COL_W-1:0] start_col,
	input wire logic [COL_W-1:0] word_cnt,
	input wire logic [COL_W-1:0] wrap_mask,
	input wire logic interleave,
	output logic [COL_W-1:0] col
);

	logic [COL_W-1:0] seq_sum;

	assign seq_sum = start_col + word_cnt;

	// ==========================================================
	// per-bit select: bits above the block stay at the start column
	for (genvar i = 0; i < COL_W; i++) begin : g_bit
		assign col[i] = wrap_mask[i] ? (interleave ? (start_col[i] ^ word_cnt[i])
			: seq_sum[i]) : start_col[i];
	end

endmodule : burst_col_gen

// *** sdram_cfg_burst.sv ***
// configuration register, read latency and burst column ordering of the dram
// assumes the controller keeps the power-on sequence; data array lives outside
`timescale 1ns/1ps

// What this block does
// - config write captures all address bits
// - fields: options, latency, wrap, burst length
// - latency codes 010 two, 011 three
// - burst codes 1,2,4,8 and full page
// - release data outputs after last word
// - wrap bit: zero sequential, one interleaved
// - interleaved full page is reserved
// - sequential wraps inside aligned block
// - interleaved is start xor counter
// - full page spans whole row length
module sdram_cfg_burst
	import sdram_cfg_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire cmd_s cmd,
	input wire logic [CFG_W-1:0] addr,
	output cfg_s burst_latency_config,
	output logic cfg_written,
	output logic [COL_W-1:0] col_addr,
	output logic col_valid,
	output logic col_is_read,
	output logic dq_oe_n
);

	// ==========================================================
	// state
	typedef struct packed {
		cfg_s cfg;
		logic cfg_seen;
		burst_st_e st;
		logic is_read;
		logic ilv;
		logic [COL_W-1:0] start;
		logic [COL_W-1:0] mask;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] words;
		logic [COL_W-1:0] col;
		logic col_valid;
		logic rd_word;
		logic rd_dly;
		logic oe_n;
	} state_s;

	state_s q;
	state_s d;

	logic cfg_cmd;
	logic rdwr_cmd;
	logic lat_ok;
	logic go;
	logic rd_go;
	logic wr_go;
	logic [CNT_W-1:0] words_dec;
	logic [COL_W-1:0] gen_col;

	// ==========================================================
	// decode
	assign cfg_cmd = (cmd == CMD_CONFIG_WRITE);
	assign rdwr_cmd = (cmd == CMD_READ) || (cmd == CMD_WRITE);
	assign lat_ok = (q.cfg.latency_field == LAT_TWO) ||
		(q.cfg.latency_field == LAT_THREE);
	assign go = rdwr_cmd && lat_ok && (words_dec != WORDS_NONE);
	assign rd_go = go && (cmd == CMD_READ);
	assign wr_go = go && (cmd == CMD_WRITE);

	// reserved codes decode to no words, so such a command starts nothing
	always_comb begin
		case (q.cfg.burst_len_field)
			BL_ONE: words_dec = WORDS_ONE;
			BL_TWO: words_dec = WORDS_TWO;
			BL_FOUR: words_dec = WORDS_FOUR;
			BL_EIGHT: words_dec = WORDS_EIGHT;
			BL_PAGE: words_dec = (q.cfg.wrap_select == WRAP_SEQ) ? PAGE_WORDS
				: WORDS_NONE;
			default: words_dec = WORDS_NONE;
		endcase
	end

	burst_col_gen u_col_gen (
		.start_col(q.start),
		.word_cnt(q.cnt[COL_W-1:0]),
		.wrap_mask(q.mask),
		.interleave(q.ilv),
		.col(gen_col)
	);

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		d.col_valid = 1'b0;
		d.rd_word = 1'b0;
		if (cfg_cmd) begin
			d.cfg = cfg_s'(addr);
			d.cfg_seen = 1'b1;
		end
		// a new read or write cuts any running burst short
		if (go) begin
			d.start = addr[COL_W-1:0];
			d.mask = COL_W'(words_dec - WORDS_ONE);
			d.ilv = (q.cfg.wrap_select == WRAP_ILV);
			d.words = words_dec;
			d.is_read = (cmd == CMD_READ);
			d.col = addr[COL_W-1:0];
			d.col_valid = 1'b1;
			d.rd_word = (cmd == CMD_READ);
			d.cnt = WORDS_ONE;
			d.st = (words_dec == WORDS_ONE) ? ST_IDLE : ST_BURST;
		end else begin
			case (q.st)
				ST_BURST: begin
					d.col = gen_col;
					d.col_valid = 1'b1;
					d.rd_word = q.is_read;
					d.cnt = q.cnt + WORDS_ONE;
					if (q.cnt == q.words - WORDS_ONE) begin
						d.st = ST_IDLE;
					end
				end
				default: d.st = ST_IDLE;
			endcase
		end
		d.rd_dly = q.rd_word;
		// drive exactly while delayed read words run, else release
		d.oe_n = (q.cfg.latency_field == LAT_TWO) ? !q.rd_word
			: !q.rd_dly;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '{cfg: cfg_s'(CFG_RESET), st: ST_IDLE, oe_n: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign burst_latency_config = q.cfg;
	assign cfg_written = q.cfg_seen;
	assign col_addr = q.col;
	assign col_valid = q.col_valid;
	assign col_is_read = q.rd_word;
	assign dq_oe_n = q.oe_n;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	cfg_capture_a: assert property (cfg_cmd |=> burst_latency_config == cfg_s'($past(addr)))
		else $error("config write not captured");
	cfg_hold_a: assert property (!cfg_cmd |=> $stable(burst_latency_config))
		else $error("config changed without write");
	lat_two_a: assert property (rd_go && q.cfg.latency_field == LAT_TWO |-> ##2 !dq_oe_n)
		else $error("data late for latency two");
	lat_three_a: assert property (rd_go && q.cfg.latency_field == LAT_THREE |-> ##3 !dq_oe_n)
		else $error("data late for latency three");
	len_four_a: assert property (wr_go && q.cfg.burst_len_field == BL_FOUR |=> col_valid[*4])
		else $error("four word burst too short");
	release_a: assert property ((rd_go && q.cfg.latency_field == LAT_TWO &&
		q.cfg.burst_len_field == BL_ONE) ##1 (!go)[*2] |-> ##1 dq_oe_n)
		else $error("data outputs not released");
	seq_order_a: assert property ((wr_go && q.cfg.wrap_select == WRAP_SEQ &&
		q.cfg.burst_len_field == BL_EIGHT && addr[2:0] == 3'h1) ##1 !go
		|-> col_addr[2:0] == 3'h1 ##1 col_addr[2:0] == 3'h2)
		else $error("sequential order wrong");
	ilv_order_a: assert property ((wr_go && q.cfg.wrap_select == WRAP_ILV &&
		q.cfg.burst_len_field == BL_FOUR && addr[1:0] == 2'h1) ##1 !go
		|-> col_addr[1:0] == 2'h1 ##1 col_addr[1:0] == 2'h0)
		else $error("interleaved order wrong");
	reserved_a: assert property (rdwr_cmd && !go && q.st == ST_IDLE |=> !col_valid)
		else $error("reserved code started a burst");
	page_len_a: assert property (q.cfg.burst_len_field == BL_PAGE &&
		q.cfg.wrap_select == WRAP_SEQ |-> words_dec == PAGE_WORDS)
		else $error("full page length wrong");

endmodule : sdram_cfg_burst

// *** ctrl_model.sv ***
// controller model: drives the command and address pins of the dram
// assumes one bench process calls its tasks at a time
`timescale 1ns/1ps
module ctrl_model
	import sdram_cfg_pkg::*;
#(
	parameter int PAUSE_CYC = 4,
	parameter int TRP_CYC = 2
)
(
	input wire logic core_clk,
	output cmd_s cmd,
	output logic [CFG_W-1:0] addr
);
	// ==========================================================
	// command issue
	initial begin
		cmd = 4'h7;
		addr = 14'h0000;
	end
	// one command, then a nop; pins change only just after an edge
	task automatic send(input logic [3:0] c, input logic [CFG_W-1:0] a);
		@(posedge core_clk);
		cmd <= c;
		addr <= a;
		@(posedge core_clk);
		cmd <= 4'h7;
	endtask : send
	// power-on pause is shortened to keep the run short; self refresh never asked
	task automatic init_seq(input logic [CFG_W-1:0] cfg);
		repeat (PAUSE_CYC) @(posedge core_clk);
		send(4'h2, 14'h0400);
		repeat (TRP_CYC) @(posedge core_clk);
		send(CMD_CONFIG_WRITE, {7'h00, cfg[6:0]});
		repeat (2) @(posedge core_clk);
		repeat (2) send(4'h1, 14'h0000);
	endtask : init_seq
endmodule : ctrl_model

// *** test_sdram_cfg_burst.sv ***
// testbench: programs the configuration, reads bursts, checks columns and enable
// assumes the controller model drives every command
`timescale 1ns/1ps
module test_sdram_cfg_burst
	import sdram_cfg_pkg::*;
;
	// ==========================================================
	// wiring
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	cmd_s cmd;
	logic [CFG_W-1:0] addr;
	cfg_s cfg;
	logic cfg_written;
	logic [COL_W-1:0] col_addr;
	logic col_valid;
	logic col_is_read;
	logic dq_oe_n;
	int n_fail = 0;
	int tests_run = 0;
	always #5 core_clk = ~core_clk;
	ctrl_model ctrl_u (.core_clk(core_clk), .cmd(cmd), .addr(addr));
	sdram_cfg_burst dut_u (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .addr(addr),
		.burst_latency_config(cfg), .cfg_written(cfg_written), .col_addr(col_addr),
		.col_valid(col_valid), .col_is_read(col_is_read), .dq_oe_n(dq_oe_n));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// program, issue one read or write, follow every word; n of 0 means it must be ignored
	task automatic burst(input logic [CFG_W-1:0] c, input logic [9:0] st, input int n,
		input int lat, input logic wr);
		logic [9:0] m;
		logic [9:0] e;
		ctrl_u.init_seq(c);
		#1;
		chk(16'(cfg), 16'(c));
		chk(16'(cfg_written), 16'h0001);
		ctrl_u.send(wr ? CMD_WRITE : CMD_READ, {4'h0, st});
		m = 10'(n - 1);
		// the first word already stands after the edge that took the command
		for (int k = 1; k <= n + lat + 1; k++) begin
			if (k > 1)
				@(posedge core_clk);
			#1;
			e = c[3] ? (st ^ 10'(k - 1)) : ((st & ~m) | ((st + 10'(k - 1)) & m));
			chk(16'(col_valid), 16'(k <= n));
			if (k <= n)
				chk(16'(col_addr), 16'(e));
			chk(16'(col_is_read), 16'(!wr && k <= n));
			chk(16'(dq_oe_n), 16'(wr || !(k >= lat && k < lat + n)));
		end
	endtask : burst
	task automatic t_reset();
		chk(16'(cfg), 16'h0000);
		chk(16'({cfg_written, dq_oe_n}), 16'h0001);
		$display("reset values done");
	endtask : t_reset
	task automatic t_seq();
		burst(14'h0022, 10'h002, 4, 2, 1'b0);
		burst(14'h0033, 10'h001, 8, 3, 1'b0);
		burst(14'h0020, 10'h009, 1, 2, 1'b0);
		burst(14'h0021, 10'h00D, 2, 2, 1'b0);
		$display("sequential bursts done");
	endtask : t_seq
	task automatic t_ilv();
		burst(14'h002B, 10'h005, 8, 2, 1'b0);
		burst(14'h003A, 10'h007, 4, 3, 1'b0);
		burst(14'h0039, 10'h001, 2, 3, 1'b0);
		$display("interleaved bursts done");
	endtask : t_ilv
	// writes walk the same columns but never turn the data outputs on
	task automatic t_write();
		burst(14'h0032, 10'h006, 4, 3, 1'b1);
		burst(14'h0023, 10'h001, 8, 2, 1'b1);
		burst(14'h002A, 10'h001, 4, 2, 1'b1);
		$display("write bursts done");
	endtask : t_write
	task automatic t_page();
		burst(14'h0027, 10'h3FC, 1024, 2, 1'b0);
		$display("full page burst done");
	endtask : t_page
	// interleaved page, reserved latency and reserved length must all be ignored
	task automatic t_resv();
		burst(14'h002F, 10'h004, 0, 2, 1'b0);
		burst(14'h0012, 10'h004, 0, 2, 1'b0);
		burst(14'h0024, 10'h004, 0, 2, 1'b1);
		$display("reserved codes done");
	endtask : t_resv
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		t_reset();
		t_seq();
		t_ilv();
		t_write();
		t_page();
		t_resv();
		final_report();
	end
	// a hang ends here with a mismatch counted
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		final_report();
	end
endmodule : test_sdram_cfg_burst
